// ---- hdl/fsr_pkg.sv ----
// fsr_pkg: constants and shared types of the flash status and read-configuration block.
// assumes: one 200 MHz clock domain; every user writes fsr_pkg::name, nothing is imported.
package fsr_pkg;
   localparam int ADDR_W = 23;
   localparam int DATA_W = 16;
   localparam int BANK_W = 5;
   localparam int BANK_HI = 22;
   localparam int BANK_LO = 18;
   localparam int PIN_W = 5;
   localparam int SYNC_W = PIN_W + ADDR_W + DATA_W;
   localparam int BOUND_HI = 5;
   // status bit positions
   localparam int SR_IDLE = 7;
   localparam int SR_ERASE_PAUSED = 6;
   localparam int SR_ERASE_FAIL = 5;
   localparam int SR_PROGRAM_FAIL = 4;
   localparam int SR_SUPPLY_INVALID = 3;
   localparam int SR_PROGRAM_PAUSED = 2;
   localparam int SR_LOCKED = 1;
   localparam int SR_BANK_WRITE = 0;
   // read configuration field positions
   localparam int CFG_READ_SELECT = 15;
   localparam int CFG_LAT_HI = 13;
   localparam int CFG_LAT_LO = 11;
   localparam int CFG_STALL_POL = 10;
   localparam int CFG_HOLD_LEN = 9;
   localparam int CFG_STALL_TIM = 8;
   localparam int CFG_ORDER = 7;
   localparam int CFG_NO_WRAP = 3;
   localparam int CFG_LEN_HI = 2;
   localparam int CFG_LEN_LO = 0;
   localparam logic [15:0] CFG_RESET = 16'hbfcf;
   localparam logic [15:0] CFG_WRITE_MASK = 16'hbfcf;
   localparam logic [2:0] LEN_4 = 3'h1;
   localparam logic [2:0] LEN_8 = 3'h2;
   localparam logic [2:0] LEN_16 = 3'h3;
   localparam logic [3:0] MASK_4 = 4'h3;
   localparam logic [3:0] MASK_8 = 4'h7;
   localparam logic [3:0] MASK_16 = 4'hf;
   // command codes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
   localparam logic [7:0] CMD_CFG_CONFIRM = 8'h03;
   typedef enum logic [1:0] {B_IDLE, B_LAT, B_DATA, B_STALL} fsr_bstate_t;
endpackage : fsr_pkg

// ---- hdl/fsr_if.sv ----
// fsr_if: carries configuration and burst control between the register side and the sequencer.
// assumes: both ends sit on the same clock; the interface itself holds no state.
`timescale 1ns/1ps
`default_nettype none
interface fsr_if;
   logic [15:0] cfg;
   logic start;
   logic abort;
   logic bclk_edge;
   logic [fsr_pkg::ADDR_W-1:0] start_addr;
   logic [fsr_pkg::ADDR_W-1:0] array_addr;
   logic valid;
   logic wait_active;
   modport ctl (output cfg, start, abort, bclk_edge, start_addr,
                input array_addr, valid, wait_active);
   modport seq (input cfg, start, abort, bclk_edge, start_addr,
                output array_addr, valid, wait_active);
endinterface : fsr_if
`default_nettype wire

// ---- hdl/fsr_sync.sv ----
// fsr_sync: two-flop synchroniser for a vector of pin levels.
// assumes: inputs are levels from outside the clock domain; INIT is the idle pin level.
`timescale 1ns/1ps
`default_nettype none
module fsr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } fsr_sync_t;
   fsr_sync_t r_q;
   fsr_sync_t r_d;
   always_comb begin
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end
   // reset to the idle level so no false edge appears at release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q <= {INIT, INIT};
      end else begin
         r_q <= r_d;
      end
   end
   assign q = r_q.s2;
endmodule : fsr_sync
`default_nettype wire

// ---- hdl/fsr_burst.sv ----
// fsr_burst: synchronous burst sequencer, steps once per burst clock rising edge.
// assumes: bclk_edge is a one-cycle pulse per burst clock rising edge; cfg is stable during a burst.
`timescale 1ns/1ps
`default_nettype none
module fsr_burst (
   input wire logic clk,
   input wire logic rst_n,
   fsr_if.seq bus
);
   typedef struct packed {
      fsr_pkg::fsr_bstate_t st;
      logic [2:0] cnt;
      logic hold;
      logic stalled;
      logic [3:0] k;
      logic [fsr_pkg::ADDR_W-1:0] start;
      logic [fsr_pkg::ADDR_W-1:0] addr;
   } fsr_burst_t;
   fsr_burst_t s_q;
   fsr_burst_t s_d;
   fsr_burst_t adv;
   logic [2:0] len;
   logic [3:0] m;
   logic [fsr_pkg::ADDR_W-1:0] m23;
   logic [fsr_pkg::ADDR_W-1:0] nxt;
   logic [3:0] kn;
   logic linear;
   logic last;
   logic edge_stall;
   always_comb begin
      len = bus.cfg[fsr_pkg::CFG_LEN_HI:fsr_pkg::CFG_LEN_LO];
      case (len)
         fsr_pkg::LEN_4: m = fsr_pkg::MASK_4;
         fsr_pkg::LEN_8: m = fsr_pkg::MASK_8;
         fsr_pkg::LEN_16: m = fsr_pkg::MASK_16;
         default: m = '0;
      endcase
      m23 = {{(fsr_pkg::ADDR_W-4){1'b0}}, m};
      linear = (m == '0) || bus.cfg[fsr_pkg::CFG_NO_WRAP];
      last = (m != '0) && (s_q.k == m);
      kn = s_q.k + 4'h1;
      if (linear) begin
         nxt = s_q.addr + 23'h1;
      end else if (bus.cfg[fsr_pkg::CFG_ORDER]) begin
         nxt = (s_q.addr & ~m23) | ((s_q.addr + 23'h1) & m23);
      end else begin
         nxt = (s_q.start & ~m23) | ((s_q.start ^ {{(fsr_pkg::ADDR_W-4){1'b0}}, kn}) & m23);
      end
      edge_stall = linear && !s_q.stalled && (nxt[fsr_pkg::BOUND_HI:0] == '0)
                   && (s_q.start[1:0] != 2'h0);
      adv = s_q;
      case (s_q.st)
         fsr_pkg::B_IDLE: begin
         end
         fsr_pkg::B_LAT: begin
            if (s_q.cnt <= 3'h1) begin
               adv.st = fsr_pkg::B_DATA;
            end else begin
               adv.cnt = s_q.cnt - 3'h1;
            end
         end
         fsr_pkg::B_DATA: begin
            if (bus.cfg[fsr_pkg::CFG_HOLD_LEN] && !s_q.hold) begin
               adv.hold = 1'b1;
            end else begin
               adv.hold = 1'b0;
               if (last) begin
                  adv.st = fsr_pkg::B_IDLE;
               end else begin
                  adv.k = kn;
                  adv.addr = nxt;
                  if (edge_stall) begin
                     adv.st = fsr_pkg::B_STALL;
                     adv.cnt = {1'b0, s_q.start[1:0]};
                     adv.stalled = 1'b1;
                  end
               end
            end
         end
         fsr_pkg::B_STALL: begin
            if (s_q.cnt <= 3'h1) begin
               adv.st = fsr_pkg::B_DATA;
            end else begin
               adv.cnt = s_q.cnt - 3'h1;
            end
         end
         default: adv.st = fsr_pkg::B_IDLE;
      endcase
      s_d = s_q;
      if (bus.abort) begin
         s_d.st = fsr_pkg::B_IDLE;
      end else if (bus.start) begin
         s_d.st = fsr_pkg::B_LAT;
         // only latency codes 2..5 are defined; 1, 6 and 7 run as their raw count, 0 runs as 1
         s_d.cnt = bus.cfg[fsr_pkg::CFG_LAT_HI:fsr_pkg::CFG_LAT_LO];
         s_d.hold = 1'b0;
         s_d.stalled = 1'b0;
         s_d.k = '0;
         s_d.start = bus.start_addr;
         s_d.addr = bus.start_addr;
      end else if (bus.bclk_edge) begin
         s_d = adv;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{st: fsr_pkg::B_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end
   assign bus.array_addr = s_q.addr;
   assign bus.valid = (s_q.st == fsr_pkg::B_DATA);
   // early timing looks at the state the next burst edge will bring
   assign bus.wait_active = bus.cfg[fsr_pkg::CFG_STALL_TIM] ?
      ((adv.st == fsr_pkg::B_LAT) || (adv.st == fsr_pkg::B_STALL)) :
      ((s_q.st == fsr_pkg::B_LAT) || (s_q.st == fsr_pkg::B_STALL));
endmodule : fsr_burst
`default_nettype wire

// ---- hdl/fsr_top.sv ----
// fsr_top: status and read-configuration logic of a multi-bank burst flash, behind its pins.
// assumes: bus pins and burst clock are asynchronous and synchronised here; the erase/program
// controller and the array run on clk and drive their ports directly.
// What this block does
// - controller idle bit is low while any bank is busy, high when idle.
// - erase, program, supply and lock error flags stick until clear command or reset.
// - program paused bit is one only while a program is suspended.
// - protected-block attempt sets lock error bit and aborts the operation.
// - while busy, bank bit is zero for addressed bank, one for another bank.
// - while idle, bank bit always reads zero.
// - in fast factory programming while busy, bank bit shows not-ready-for-next-word.
// - leaving fast factory programming reads bank bit zero with idle bit high.
// - each stored status one drives a high data line, zero a low line.
// - read configuration changes only through the setup-confirm command pair.
// - reset forces read select to one, asynchronous reads.
// - read select one gives asynchronous reads, zero gives synchronous bursts.
// - bursts run in any block and continue across bank boundaries.
// - first burst word appears after the programmed latency in burst clocks.
// - stall polarity bit picks active-low or active-high stall output.
// - each burst word holds one or two burst clocks per hold bit.
// - stall output is asserted while burst data is not valid.
// - stall timing bit one asserts the stall indicator one clock earlier.
// - burst order bit picks interleaved or sequential addresses.
// - burst length field selects 4, 8, 16 words or continuous.
`timescale 1ns/1ps
`default_nettype none
module fsr_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic burst_clk,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   input wire logic latch_n,
   input wire logic [fsr_pkg::ADDR_W-1:0] addr,
   input wire logic [fsr_pkg::DATA_W-1:0] dq_in,
   output logic [fsr_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   output logic stall_out,
   input wire logic pec_busy,
   input wire logic [fsr_pkg::BANK_W-1:0] pec_bank,
   input wire logic fast_factory_programming,
   input wire logic ffp_word_busy,
   input wire logic erase_paused,
   input wire logic program_paused,
   input wire logic erase_fail_evt,
   input wire logic program_fail_evt,
   input wire logic supply_invalid_evt,
   input wire logic locked_attempt_evt,
   output logic op_abort,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [fsr_pkg::ADDR_W-1:0] cmd_addr,
   output logic [fsr_pkg::ADDR_W-1:0] array_addr,
   input wire logic [fsr_pkg::DATA_W-1:0] array_data,
   output logic [15:0] read_cfg
);
   typedef struct packed {
      logic [fsr_pkg::PIN_W-1:0] pin_prev;
      logic [15:0] cfg;
      logic cfg_armed;
      logic read_status;
      logic erase_fail;
      logic program_fail;
      logic supply_invalid;
      logic locked_err;
      logic valid_dly;
      logic [fsr_pkg::DATA_W-1:0] dq_out;
      logic dq_oe;
      logic stall_out;
      logic op_abort;
      logic cmd_valid;
      logic [7:0] cmd_code;
      logic [fsr_pkg::ADDR_W-1:0] cmd_addr;
      logic [fsr_pkg::ADDR_W-1:0] array_addr;
   } fsr_top_t;

   localparam logic [fsr_pkg::SYNC_W-1:0] SYNC_INIT =
      {{fsr_pkg::PIN_W{1'b1}}, {(fsr_pkg::ADDR_W + fsr_pkg::DATA_W){1'b0}}};

   fsr_top_t s_q;
   fsr_top_t s_d;
   fsr_if ifc ();

   logic [fsr_pkg::SYNC_W-1:0] sync_q;
   logic [fsr_pkg::PIN_W-1:0] pins;
   logic [fsr_pkg::ADDR_W-1:0] a_s;
   logic [fsr_pkg::DATA_W-1:0] d_s;
   logic bclk_s;
   logic ce_s;
   logic oe_s;
   logic we_s;
   logic lat_s;
   logic we_rise;
   logic lat_fall;
   logic bclk_rise;
   logic sync_mode;
   logic reading;
   logic [7:0] status;
   logic [7:0] code;
   logic clear_status;

   fsr_sync #(
      .W(fsr_pkg::SYNC_W),
      .INIT(SYNC_INIT)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({burst_clk, latch_n, wr_en_n, out_en_n, chip_en_n, addr, dq_in}),
      .q(sync_q)
   );

   fsr_burst u_burst (
      .clk(clk),
      .rst_n(rst_n),
      .bus(ifc.seq)
   );

   always_comb begin
      pins = sync_q[fsr_pkg::SYNC_W-1 -: fsr_pkg::PIN_W];
      a_s = sync_q[fsr_pkg::DATA_W +: fsr_pkg::ADDR_W];
      d_s = sync_q[fsr_pkg::DATA_W-1:0];
      bclk_s = pins[4];
      lat_s = pins[3];
      we_s = pins[2];
      oe_s = pins[1];
      ce_s = pins[0];
      we_rise = we_s && !s_q.pin_prev[2] && !ce_s;
      lat_fall = !lat_s && s_q.pin_prev[3] && !ce_s;
      bclk_rise = bclk_s && !s_q.pin_prev[4];
      sync_mode = !s_q.cfg[fsr_pkg::CFG_READ_SELECT];
      reading = !ce_s && !oe_s && we_s;
      code = d_s[7:0];
      clear_status = we_rise && (code == fsr_pkg::CMD_CLEAR_STATUS) && !s_q.cfg_armed;
   end

   // status image; the controller owns the live bits, this block owns the sticky ones
   always_comb begin
      status = '0;
      status[fsr_pkg::SR_IDLE] = !pec_busy;
      status[fsr_pkg::SR_ERASE_PAUSED] = erase_paused;
      status[fsr_pkg::SR_ERASE_FAIL] = s_q.erase_fail;
      status[fsr_pkg::SR_PROGRAM_FAIL] = s_q.program_fail;
      status[fsr_pkg::SR_SUPPLY_INVALID] = s_q.supply_invalid;
      status[fsr_pkg::SR_PROGRAM_PAUSED] = program_paused;
      status[fsr_pkg::SR_LOCKED] = s_q.locked_err;
      if (!pec_busy) begin
         status[fsr_pkg::SR_BANK_WRITE] = 1'b0;
      end else if (fast_factory_programming) begin
         status[fsr_pkg::SR_BANK_WRITE] = ffp_word_busy;
      end else begin
         status[fsr_pkg::SR_BANK_WRITE] = (pec_bank != a_s[fsr_pkg::BANK_HI:fsr_pkg::BANK_LO]);
      end
   end

   always_comb begin
      ifc.cfg = s_q.cfg;
      ifc.start = lat_fall && sync_mode;
      ifc.abort = ce_s || !sync_mode;
      ifc.bclk_edge = bclk_rise;
      ifc.start_addr = a_s;
   end

   always_comb begin
      s_d = s_q;
      s_d.pin_prev = pins;
      s_d.cmd_valid = 1'b0;
      s_d.op_abort = 1'b0;
      // a set arriving with a clear wins, so no error event is lost
      s_d.erase_fail = erase_fail_evt || (s_q.erase_fail && !clear_status);
      s_d.program_fail = program_fail_evt || (s_q.program_fail && !clear_status);
      s_d.supply_invalid = supply_invalid_evt || (s_q.supply_invalid && !clear_status);
      s_d.locked_err = locked_attempt_evt || (s_q.locked_err && !clear_status);
      s_d.op_abort = locked_attempt_evt;
      if (we_rise) begin
         if (s_q.cfg_armed) begin
            s_d.cfg_armed = 1'b0;
            if (code == fsr_pkg::CMD_CFG_CONFIRM) begin
               // the new value travels on the address lines
               s_d.cfg = a_s[15:0] & fsr_pkg::CFG_WRITE_MASK;
               s_d.read_status = 1'b0;
            end else begin
               s_d.read_status = 1'b1;
            end
         end else begin
            case (code)
               fsr_pkg::CMD_CFG_SETUP: begin
                  s_d.cfg_armed = 1'b1;
               end
               fsr_pkg::CMD_READ_ARRAY: begin
                  s_d.read_status = 1'b0;
               end
               fsr_pkg::CMD_READ_STATUS: begin
                  s_d.read_status = 1'b1;
               end
               fsr_pkg::CMD_CLEAR_STATUS: begin
               end
               default: begin
                  s_d.read_status = 1'b1;
                  s_d.cmd_valid = 1'b1;
                  s_d.cmd_code = code;
                  s_d.cmd_addr = a_s;
               end
            endcase
         end
      end
      s_d.valid_dly = ifc.valid;
      s_d.array_addr = sync_mode ? ifc.array_addr : a_s;
      s_d.dq_oe = reading;
      if (s_q.read_status) begin
         s_d.dq_out = {8'h00, status};
      end else if (!sync_mode) begin
         s_d.dq_out = array_data;
      end else if (s_q.valid_dly) begin
         s_d.dq_out = array_data;
      end
      // stall pin level: active level follows the polarity bit
      s_d.stall_out = (sync_mode && !ce_s && ifc.wait_active) ~^
                      s_q.cfg[fsr_pkg::CFG_STALL_POL];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{pin_prev: {fsr_pkg::PIN_W{1'b1}},
                  cfg: fsr_pkg::CFG_RESET,
                  stall_out: 1'b0,
                  default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign dq_out = s_q.dq_out;
   assign dq_oe = s_q.dq_oe;
   assign stall_out = s_q.stall_out;
   assign op_abort = s_q.op_abort;
   assign cmd_valid = s_q.cmd_valid;
   assign cmd_code = s_q.cmd_code;
   assign cmd_addr = s_q.cmd_addr;
   assign array_addr = s_q.array_addr;
   assign read_cfg = s_q.cfg;
endmodule : fsr_top
`default_nettype wire

// ---- sim/fsr_checker.sv ----
// fsr_checker: assertions on the status and configuration ports of fsr_top.
// assumes: bound into fsr_top; status read mode is followed from the command pins.
`timescale 1ns/1ps
`default_nettype none
module fsr_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic wr_en_n,
   input wire logic [fsr_pkg::ADDR_W-1:0] addr,
   input wire logic [fsr_pkg::DATA_W-1:0] dq_in,
   input wire logic [fsr_pkg::DATA_W-1:0] dq_out,
   input wire logic dq_oe,
   input wire logic pec_busy,
   input wire logic [fsr_pkg::BANK_W-1:0] pec_bank,
   input wire logic fast_factory_programming,
   input wire logic ffp_word_busy,
   input wire logic erase_paused,
   input wire logic program_paused,
   input wire logic locked_attempt_evt,
   input wire logic op_abort,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] read_cfg
);
   logic stat_mode_q;
   logic [3:0] calm_q;
   logic [35:0] seen_q;
   logic [35:0] now_sig;
   logic stat_ok;
   logic wr_prev_q;
   logic armed_q;
   logic [3:0] conf_q;
   logic wr_rise;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   assign now_sig = {chip_en_n, out_en_n, wr_en_n, addr, pec_busy, pec_bank,
      fast_factory_programming, ffp_word_busy, program_paused, erase_paused};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_mode_q <= 1'b0;
         calm_q <= 4'h0;
         seen_q <= '0;
         wr_prev_q <= 1'b1;
         armed_q <= 1'b0;
         conf_q <= 4'h0;
      end else begin
         seen_q <= now_sig;
         wr_prev_q <= wr_en_n;
         // a confirm opens a short window in which the config may change
         if (wr_rise && armed_q && dq_in[7:0] == fsr_pkg::CMD_CFG_CONFIRM) begin
            conf_q <= 4'hf;
         end else if (conf_q != 4'h0) begin
            conf_q <= conf_q - 4'h1;
         end
         if (wr_rise && armed_q) begin
            armed_q <= 1'b0;
            stat_mode_q <= (dq_in[7:0] != fsr_pkg::CMD_CFG_CONFIRM);
         end else if (wr_rise && dq_in[7:0] == fsr_pkg::CMD_CFG_SETUP) begin
            armed_q <= 1'b1;
         end else if (wr_rise && dq_in[7:0] != fsr_pkg::CMD_CLEAR_STATUS) begin
            stat_mode_q <= (dq_in[7:0] != fsr_pkg::CMD_READ_ARRAY);
         end
         if (cmd_valid || now_sig != seen_q) begin
            calm_q <= 4'h0;
         end else if (calm_q != 4'hf) begin
            calm_q <= calm_q + 4'h1;
         end
      end
   end
   assign wr_rise = wr_en_n && !wr_prev_q && !chip_en_n;
   // pins cross two sync flops and a register before dq_out settles;
   // a pin that moved this cycle has not reached dq_out yet
   assign stat_ok = stat_mode_q && dq_oe && calm_q >= 4'h6 && now_sig == seen_q;
   a_lock_abort: assert property (locked_attempt_evt |=> op_abort)
      else $error("no abort after locked attempt");
   a_cfg_reset: assert property ($rose(rst_n) |-> read_cfg == fsr_pkg::CFG_RESET)
      else $error("config not at reset value");
   a_cfg_by_cmd: assert property ($changed(read_cfg) |-> conf_q != 4'h0)
      else $error("config changed without confirm");
   a_cmd_code: assert property (cmd_valid |-> {8'h00, cmd_code} == $past(dq_in, 3))
      else $error("passed command code wrong");
   a_idle_bit: assert property (stat_ok |-> dq_out == {8'h00, !pec_busy, dq_out[6:0]})
      else $error("idle bit or upper byte wrong");
   a_bank_bit: assert property (stat_ok && pec_busy && !fast_factory_programming |->
      dq_out[0] == (addr[fsr_pkg::BANK_HI:fsr_pkg::BANK_LO] != pec_bank))
      else $error("bank write bit wrong");
   a_word_ready: assert property (stat_ok && pec_busy && fast_factory_programming |->
      dq_out[0] == ffp_word_busy)
      else $error("word ready bit wrong");
   a_idle_bank: assert property (stat_ok && dq_out[7] |-> !dq_out[0])
      else $error("bank bit set while idle");
   a_paused_bits: assert property (stat_ok |->
      dq_out[2] == program_paused && dq_out[6] == erase_paused)
      else $error("suspend bits wrong");
   a_flags_stick: assert property (stat_ok && $past(stat_ok) |->
      ($past(dq_out[7:0]) & 8'h3a & ~dq_out[7:0]) == 8'h00)
      else $error("error flag dropped");
   c_status: cover property (stat_ok && !pec_busy);
   c_abort: cover property (op_abort);
   c_cfg: cover property ($changed(read_cfg));
endmodule : fsr_checker
bind fsr_top fsr_checker i_fsr_checker (.*);
`default_nettype wire

// ---- sim/fsr_host.sv ----
// fsr_host: host memory controller model driving the pins and the burst clock.
// assumes: clk is the device clock; burst_clk stands still outside bursts.
`timescale 1ns/1ps
`default_nettype none
module fsr_host (
   input wire logic clk,
   output logic burst_clk,
   output logic chip_en_n,
   output logic out_en_n,
   output logic wr_en_n,
   output logic latch_n,
   output logic [fsr_pkg::ADDR_W-1:0] addr,
   output logic [fsr_pkg::DATA_W-1:0] dq_in,
   input wire logic [fsr_pkg::DATA_W-1:0] dq_out,
   input wire logic stall_out
);
   logic [15:0] words [4];
   int nw;
   logic saw_stall;
   initial begin
      {burst_clk, chip_en_n, out_en_n, wr_en_n, latch_n} = 5'h0f;
      addr = '0;
      dq_in = '0;
   end
   // released lines flip to the inverse so stale values cannot pass
   task automatic cmd(input logic [7:0] code, input logic [22:0] a);
      @(posedge clk);
      chip_en_n <= 1'b0;
      wr_en_n <= 1'b0;
      addr <= a;
      dq_in <= {8'h00, code};
      repeat (4) @(posedge clk);
      wr_en_n <= 1'b1;
      repeat (3) @(posedge clk);
      chip_en_n <= 1'b1;
      addr <= ~a;
      dq_in <= ~{8'h00, code};
      repeat (6) @(posedge clk);
   endtask : cmd
   task automatic rd(input logic [22:0] a, output logic [15:0] v);
      @(posedge clk);
      chip_en_n <= 1'b0;
      out_en_n <= 1'b0;
      addr <= a;
      repeat (9) @(posedge clk);
      v = dq_out;
      chip_en_n <= 1'b1;
      out_en_n <= 1'b1;
      addr <= ~a;
      repeat (4) @(posedge clk);
   endtask : rd
   // burst clock of 48 ns, unrelated to clk; words taken only with stall inactive;
   // pol is the active stall level the host has programmed
   task automatic burst(input logic [22:0] a, input logic pol);
      nw = 0;
      saw_stall = 1'b0;
      @(posedge clk);
      chip_en_n <= 1'b0;
      out_en_n <= 1'b0;
      addr <= a;
      latch_n <= 1'b0;
      repeat (4) @(posedge clk);
      latch_n <= 1'b1;
      repeat (24) begin
         #24;
         if (stall_out === pol) begin
            saw_stall = 1'b1;
         end else if (saw_stall && nw < 4) begin
            words[nw] = dq_out;
            nw++;
         end
         burst_clk = 1'b1;
         #24;
         burst_clk = 1'b0;
      end
      @(posedge clk);
      chip_en_n <= 1'b1;
      out_en_n <= 1'b1;
      addr <= ~a;
   endtask : burst
endmodule : fsr_host
`default_nettype wire

// ---- sim/tb_fsr_top.sv ----
// tb_fsr_top: self-checking bench for the flash status and read configuration block.
// assumes: fsr_host drives the pins; the bench plays the controller and the array.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_fsr_top;
   localparam logic [22:0] BANK3 = 23'h0c_0000;
   logic clk, rst_n, burst_clk, chip_en_n, out_en_n, wr_en_n, latch_n;
   logic [22:0] addr, cmd_addr, array_addr;
   logic [15:0] dq_in, dq_out, array_data, read_cfg, v;
   logic dq_oe, stall_out, pec_busy, fast_factory_programming, ffp_word_busy;
   logic erase_paused, program_paused, erase_fail_evt, program_fail_evt;
   logic supply_invalid_evt, locked_attempt_evt, op_abort, cmd_valid;
   logic [4:0] pec_bank;
   logic [7:0] cmd_code;
   int fail_count = 0;
   int checks = 0;
   fsr_top i_fsr_top (.*);
   fsr_host i_fsr_host (.*);
   assign array_data = array_addr[15:0] ^ 16'ha5a5;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic finish_test;
      $display("counts: %0d checks, %0d mismatches", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic stat(input logic b, input logic [4:0] bk, input logic f, w, pp, ep,
                       input logic [7:0] e);
      @(posedge clk);
      {pec_busy, pec_bank, fast_factory_programming, ffp_word_busy} <= {b, bk, f, w};
      {program_paused, erase_paused} <= {pp, ep};
      i_fsr_host.cmd(fsr_pkg::CMD_READ_STATUS, BANK3);
      i_fsr_host.rd(BANK3, v);
      `CHK(v, {8'h00, e})
   endtask : stat
   task automatic pulse(input logic [3:0] e);
      @(posedge clk);
      {erase_fail_evt, program_fail_evt, supply_invalid_evt, locked_attempt_evt} <= e;
      @(posedge clk);
      {erase_fail_evt, program_fail_evt, supply_invalid_evt, locked_attempt_evt} <= 4'h0;
   endtask : pulse
   initial begin
      #400000;
      fail_count++;
      finish_test();
   end
   initial begin
      rst_n = 1'b0;
      {pec_busy, pec_bank, fast_factory_programming, ffp_word_busy} = '0;
      {erase_paused, program_paused} = '0;
      {erase_fail_evt, program_fail_evt, supply_invalid_evt, locked_attempt_evt} = '0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK(read_cfg, fsr_pkg::CFG_RESET)
      `CHK(stall_out, 1'b0)
      $display("test reset done");
      stat(1'b0, 5'd3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
      stat(1'b1, 5'd3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
      stat(1'b1, 5'd5, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01);
      stat(1'b1, 5'd3, 1'b1, 1'b1, 1'b0, 1'b0, 8'h01);
      stat(1'b1, 5'd5, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      stat(1'b0, 5'd3, 1'b1, 1'b1, 1'b0, 1'b0, 8'h80);
      stat(1'b0, 5'd3, 1'b0, 1'b0, 1'b1, 1'b1, 8'hc4);
      $display("test status bits done");
      pulse(4'hf);
      stat(1'b0, 5'd3, 1'b0, 1'b0, 1'b0, 1'b0, 8'hba);
      stat(1'b0, 5'd3, 1'b0, 1'b0, 1'b0, 1'b0, 8'hba);
      i_fsr_host.cmd(fsr_pkg::CMD_CLEAR_STATUS, BANK3);
      stat(1'b0, 5'd3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
      $display("test error flags done");
      i_fsr_host.cmd(fsr_pkg::CMD_CFG_SETUP, 23'h00_0000);
      `CHK(read_cfg, fsr_pkg::CFG_RESET)
      i_fsr_host.cmd(fsr_pkg::CMD_CFG_CONFIRM, 23'h00_5cf1);
      `CHK(read_cfg, 16'h1cc1)
      $display("test configuration done");
      i_fsr_host.burst(23'h00_0102, 1'b1);
      `CHK(i_fsr_host.saw_stall, 1'b1)
      `CHK(i_fsr_host.nw, 4)
      for (int k = 0; k < 4; k++) begin
         `CHK(i_fsr_host.words[k], (16'h0100 | ((16'h0002 + k) & 16'h0003)) ^ 16'ha5a5)
      end
      $display("test burst done");
      i_fsr_host.cmd(fsr_pkg::CMD_CFG_SETUP, 23'h00_0000);
      i_fsr_host.cmd(8'h40, BANK3);
      `CHK(read_cfg, 16'h1cc1)
      i_fsr_host.cmd(8'h40, 23'h00_0123);
      `CHK(cmd_code, 8'h40)
      `CHK(cmd_addr, 23'h00_0123)
      i_fsr_host.cmd(fsr_pkg::CMD_CFG_SETUP, 23'h00_0000);
      i_fsr_host.cmd(fsr_pkg::CMD_CFG_CONFIRM, 23'h00_1a41);
      `CHK(read_cfg, 16'h1a41)
      i_fsr_host.burst(23'h00_0201, 1'b0);
      `CHK(i_fsr_host.saw_stall, 1'b1)
      `CHK(i_fsr_host.nw, 4)
      for (int k = 0; k < 4; k++) begin
         `CHK(i_fsr_host.words[k], (16'h0200 | (16'h0001 ^ (k >> 1))) ^ 16'ha5a5)
      end
      $display("test second burst done");
      pulse(4'h4);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK(read_cfg, fsr_pkg::CFG_RESET)
      stat(1'b0, 5'd3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
      $display("test second reset done");
      finish_test();
   end
endmodule : tb_fsr_top
`default_nettype wire
